// ### logic/sls_map.svh
`ifndef SLS_MAP_SVH
`define SLS_MAP_SVH
`define SLS_DATA_WIDTH      16
`define SLS_STACK_DEPTH     33
`define SLS_OP_WIDTH        4
`define SLS_OP_CONTINUE     4'h0
`define SLS_OP_LOOP_D       4'h1
`define SLS_OP_LOOP_A       4'h2
`define SLS_OP_LOOP_MARK    4'h3
`define SLS_OP_POP_D        4'h4
`define SLS_OP_POP_C        4'h5
`define SLS_OP_PUSH_D       4'h6
`define SLS_OP_PUSH_C       4'h7
`define SLS_OP_DEC_BR_TOP   4'h8
`define SLS_RESET_ADDR      16'h0000
`endif

// ### logic/sls_pkg.sv
`include "sls_map.svh"
package sls_pkg;
	typedef logic [`SLS_DATA_WIDTH-1:0] sls_word_t;
	typedef logic [`SLS_OP_WIDTH-1:0]   sls_op_t;
	typedef enum logic [1:0] {SLS_IDLE, SLS_ISSUE} sls_state_e;
endpackage

// ### logic/sls_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "sls_map.svh"
interface sls_if;
	logic [`SLS_OP_WIDTH-1:0]   op;
	logic [`SLS_DATA_WIDTH-1:0] a_in;
	logic [`SLS_DATA_WIDTH-1:0] d_from_host;
	logic                       d_host_oe_n;
	logic [`SLS_DATA_WIDTH-1:0] d_from_dev;
	logic                       d_dev_oe_n;
	logic                       data_port_output_enable;
	logic [`SLS_DATA_WIDTH-1:0] addr;
	logic [`SLS_DATA_WIDTH-1:0] counter;
	logic [`SLS_DATA_WIDTH-1:0] top;
	logic                       stack_empty;
	logic                       stack_full;
	logic [`SLS_DATA_WIDTH-1:0] d_bus;
	assign d_bus = !d_dev_oe_n ? d_from_dev : (!d_host_oe_n ? d_from_host : '0);
	modport dev (input op, a_in, d_bus, data_port_output_enable,
		output d_from_dev, d_dev_oe_n, addr, counter, top, stack_empty, stack_full);
	modport host (input addr, counter, top, stack_empty, stack_full, d_bus, d_dev_oe_n,
		output op, a_in, d_from_host, d_host_oe_n, data_port_output_enable);
endinterface
`default_nettype wire

// ### logic/sls_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "sls_map.svh"
// What this block does
// - Loop from D: push address+1, load counter
// - Loop from A: push address+1, load counter
// - Loop marker: push address+1, counter kept
// - Pop to D: pop top, drive D
// - Host enables D output during pop
// - Pop to counter: pop top into counter
// - Push from D: D becomes new top
// - Push counter: counter becomes new top
// - Host keeps D drivers off when sourced
// - Counted loop closes with decrement branch
// - Marker pairs with branches to top
// - Decrement branch: to top unless one
module sls_device #(
	parameter int DEPTH = `SLS_STACK_DEPTH
) (
	input  wire logic i_clock,
	input  wire logic i_rstn,
	sls_if.dev        bus
);
	localparam int PW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [`SLS_DATA_WIDTH-1:0] addr;
		logic [`SLS_DATA_WIDTH-1:0] counter;
		logic [PW-1:0]              sp;
		logic [`SLS_DATA_WIDTH-1:0] dout;
		logic                       dout_en;
	} sls_dev_s;
	sls_dev_s st;
	sls_dev_s next_st;
	logic [`SLS_DATA_WIDTH-1:0] stack [DEPTH];
	logic                       do_push;
	logic [`SLS_DATA_WIDTH-1:0] push_val;
	logic                       do_pop;
	logic [`SLS_DATA_WIDTH-1:0] tos;
	logic [`SLS_DATA_WIDTH-1:0] next_seq;
	assign tos = (st.sp == '0) ? '0 : stack[st.sp - PW'(1)];
	assign next_seq = st.addr + `SLS_DATA_WIDTH'(1);
	always_comb
	begin
		next_st = st;
		do_push = 1'b0;
		push_val = next_seq;
		do_pop = 1'b0;
		next_st.addr = next_seq;
		next_st.dout_en = 1'b0;
		case (bus.op)
			`SLS_OP_LOOP_D:
			begin
				do_push = 1'b1;
				next_st.counter = bus.d_bus;
			end
			`SLS_OP_LOOP_A:
			begin
				do_push = 1'b1;
				next_st.counter = bus.a_in;
			end
			`SLS_OP_LOOP_MARK: do_push = 1'b1;
			`SLS_OP_POP_D:
			begin
				do_pop = 1'b1;
				next_st.dout = tos;
				next_st.dout_en = 1'b1;
			end
			`SLS_OP_POP_C:
			begin
				do_pop = 1'b1;
				next_st.counter = tos;
			end
			`SLS_OP_PUSH_D:
			begin
				do_push = 1'b1;
				push_val = bus.d_bus;
			end
			`SLS_OP_PUSH_C:
			begin
				do_push = 1'b1;
				push_val = st.counter;
			end
			`SLS_OP_DEC_BR_TOP:
			begin
				next_st.counter = st.counter - `SLS_DATA_WIDTH'(1);
				if (st.counter != `SLS_DATA_WIDTH'(1))
					next_st.addr = tos;
				else
					do_pop = 1'b1;
			end
			default: ;
		endcase
		// Overflow drops the push, underflow the pop: stack pointer never wraps
		if (do_push && st.sp != PW'(DEPTH))
			next_st.sp = st.sp + PW'(1);
		if (do_pop && st.sp != '0)
			next_st.sp = st.sp - PW'(1);
		if (!i_rstn)
		begin
			next_st.addr = `SLS_RESET_ADDR;
			next_st.counter = '0;
			next_st.sp = '0;
			next_st.dout = '0;
			next_st.dout_en = 1'b0;
		end
	end
	always_ff @(posedge i_clock)
	begin
		st <= next_st;
		if (i_rstn && do_push && st.sp != PW'(DEPTH))
			stack[st.sp] <= push_val;
	end
	// Driver gated by host enable so pop data only appears when allowed
	assign bus.d_from_dev = st.dout;
	assign bus.d_dev_oe_n = !(st.dout_en && bus.data_port_output_enable);
	assign bus.addr = st.addr;
	assign bus.counter = st.counter;
	assign bus.top = tos;
	assign bus.stack_empty = (st.sp == '0);
	assign bus.stack_full = (st.sp == PW'(DEPTH));
endmodule
`default_nettype wire

// ### logic/sls_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "sls_map.svh"
module sls_host (
	input  wire logic                       i_clock,
	input  wire logic                       i_rstn,
	input  wire logic                       i_valid,
	input  wire logic [`SLS_OP_WIDTH-1:0]   i_op,
	input  wire logic [`SLS_DATA_WIDTH-1:0] i_a,
	input  wire logic [`SLS_DATA_WIDTH-1:0] i_d,
	output logic                            o_ready,
	output logic [`SLS_DATA_WIDTH-1:0]      o_pop_data,
	output logic                            o_pop_valid,
	sls_if.host                             bus
);
	typedef struct packed {
		logic [`SLS_OP_WIDTH-1:0]   op;
		logic [`SLS_DATA_WIDTH-1:0] a;
		logic [`SLS_DATA_WIDTH-1:0] d;
		logic                       pop_wait;
		logic                       drive_en;
		logic [`SLS_DATA_WIDTH-1:0] pop_data;
		logic                       pop_valid;
	} sls_host_s;
	sls_host_s st;
	sls_host_s next_st;
	always_comb
	begin
		next_st = st;
		next_st.op = i_valid ? i_op : `SLS_OP_CONTINUE;
		next_st.a = i_a;
		next_st.d = i_d;
		next_st.pop_wait = i_valid && (i_op == `SLS_OP_POP_D);
		// Device drives one cycle after it takes the pop, so enable spans both cycles
		next_st.drive_en = st.pop_wait;
		next_st.pop_valid = st.drive_en;
		if (st.drive_en)
			next_st.pop_data = bus.d_bus;
		if (!i_rstn)
		begin
			next_st.op = `SLS_OP_CONTINUE;
			next_st.a = '0;
			next_st.d = '0;
			next_st.pop_wait = 1'b0;
			next_st.drive_en = 1'b0;
			next_st.pop_data = '0;
			next_st.pop_valid = 1'b0;
		end
	end
	always_ff @(posedge i_clock)
		st <= next_st;
	assign o_ready = 1'b1;
	assign o_pop_data = st.pop_data;
	assign o_pop_valid = st.pop_valid;
	assign bus.op = st.op;
	assign bus.a_in = st.a;
	assign bus.d_from_host = st.d;
	// Drive D only for data-sourced ops; enable device drivers only on pop
	assign bus.d_host_oe_n = !(st.op == `SLS_OP_LOOP_D || st.op == `SLS_OP_PUSH_D);
	assign bus.data_port_output_enable = (st.pop_wait || st.drive_en) && bus.d_host_oe_n;
endmodule
`default_nettype wire

// ### testbench/sls_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "sls_map.svh"
module sls_assertions (
	input wire logic               i_clock,
	input wire logic               i_rstn,
	input wire sls_pkg::sls_op_t   op,
	input wire sls_pkg::sls_word_t a_in,
	input wire sls_pkg::sls_word_t d_bus,
	input wire logic               d_dev_oe_n,
	input wire logic               data_port_output_enable,
	input wire sls_pkg::sls_word_t addr,
	input wire sls_pkg::sls_word_t counter,
	input wire sls_pkg::sls_word_t top,
	input wire logic               stack_empty,
	input wire logic               stack_full
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	sequence s_push(logic [3:0] code);
		op == code && !stack_full;
	endsequence
	sequence s_pop(logic [3:0] code);
		op == code && !stack_empty;
	endsequence
	AST_LOOP_D: assert property (s_push(`SLS_OP_LOOP_D) |=> top == $past(addr) + 1'b1
		&& counter == $past(d_bus)) else $error("loop from D wrong");
	AST_LOOP_A: assert property (s_push(`SLS_OP_LOOP_A) |=> top == $past(addr) + 1'b1
		&& counter == $past(a_in)) else $error("loop from A wrong");
	AST_MARK: assert property (s_push(`SLS_OP_LOOP_MARK) |=> top == $past(addr) + 1'b1
		&& $stable(counter)) else $error("loop marker wrong");
	AST_POP_D: assert property (s_pop(`SLS_OP_POP_D) and data_port_output_enable
		|=> !d_dev_oe_n && d_bus == $past(top)) else $error("pop to D wrong");
	AST_POP_C: assert property (s_pop(`SLS_OP_POP_C) |=> counter == $past(top))
		else $error("pop to counter wrong");
	AST_PUSH_D: assert property (s_push(`SLS_OP_PUSH_D) |=> top == $past(d_bus))
		else $error("push from D wrong");
	AST_PUSH_C: assert property (s_push(`SLS_OP_PUSH_C) |=> top == $past(counter))
		else $error("push counter wrong");
	AST_DEC_TAKEN: assert property (op == `SLS_OP_DEC_BR_TOP && counter != 16'h0001
		|=> addr == $past(top) && counter == $past(counter) - 1'b1) else $error("branch wrong");
	AST_DEC_DONE: assert property (op == `SLS_OP_DEC_BR_TOP && counter == 16'h0001
		|=> addr == $past(addr) + 1'b1 && counter == '0) else $error("loop end wrong");
endmodule
`default_nettype wire

// ### testbench/sequencer_loop_stack_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sls_map.svh"
module sequencer_loop_stack_ops_tb;
	logic               i_clock = 1'b0;
	logic               i_rstn  = 1'b0;
	logic               i_valid = 1'b0;
	sls_pkg::sls_op_t   i_op    = `SLS_OP_CONTINUE;
	sls_pkg::sls_word_t i_a     = '0;
	sls_pkg::sls_word_t i_d     = '0;
	sls_pkg::sls_word_t pop_data;
	int                 bad_count = 0;
	int                 check_count = 0;
	sls_if bus ();
	sls_device u_sls_device (.i_clock(i_clock), .i_rstn(i_rstn), .bus(bus));
	sls_host u_sls_host (.i_clock(i_clock), .i_rstn(i_rstn), .i_valid(i_valid), .i_op(i_op),
		.i_a(i_a), .i_d(i_d), .o_ready(), .o_pop_data(pop_data), .o_pop_valid(), .bus(bus));
	sls_assertions u_sls_assertions (.i_clock(i_clock), .i_rstn(i_rstn), .op(bus.op),
		.a_in(bus.a_in), .d_bus(bus.d_bus), .d_dev_oe_n(bus.d_dev_oe_n),
		.data_port_output_enable(bus.data_port_output_enable), .addr(bus.addr),
		.counter(bus.counter), .top(bus.top), .stack_empty(bus.stack_empty),
		.stack_full(bus.stack_full));
	initial
		forever #20 i_clock = ~i_clock;
	// Host registers, device executes next edge, pop data lands one later
	task automatic run(input sls_pkg::sls_op_t op, input sls_pkg::sls_word_t a, d);
		@(posedge i_clock);
		i_valid <= 1'b1;
		i_op    <= op;
		i_a     <= a;
		i_d     <= d;
		@(posedge i_clock);
		i_valid <= 1'b0;
		i_op    <= `SLS_OP_CONTINUE;
		repeat (3) @(posedge i_clock);
		#1;
	endtask
	task automatic check(input sls_pkg::sls_word_t got, exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge i_clock);
		i_rstn <= 1'b1;
		run(`SLS_OP_LOOP_A, 16'h0005, '0);
		check(bus.counter, 16'h0005);
		run(`SLS_OP_LOOP_D, 16'h0009, 16'h0003);
		check(bus.counter, 16'h0003);
		run(`SLS_OP_LOOP_MARK, 16'h0009, 16'h0009);
		check(bus.counter, 16'h0003);
		run(`SLS_OP_PUSH_C, '0, '0);
		check(bus.top, 16'h0003);
		run(`SLS_OP_PUSH_D, '0, 16'h1234);
		check(bus.top, 16'h1234);
		run(`SLS_OP_POP_D, '0, '0);
		check(pop_data, 16'h1234);
		check(bus.top, 16'h0003);
		run(`SLS_OP_DEC_BR_TOP, '0, '0);
		check(bus.counter, 16'h0002);
		run(`SLS_OP_POP_C, '0, '0);
		check(bus.counter, 16'h0003);
		run(`SLS_OP_LOOP_A, 16'h0001, '0);
		run(`SLS_OP_DEC_BR_TOP, '0, '0);
		check(bus.counter, 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire
